// file: pcie_ext_cap_power_acs_ltr_regs.sv
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
`include "pcie_ext_cap_params.svh"

// Contract
// R1 - Power data byte 7:0 is read-only base power in watts, reset 04h.
// R2 - EEPROM autoload may replace base power; software then reads loaded value.
// R3 - Read-only scale field in bits 9:8, reset zero.
// R4 - Read-only sub-state field in bits 12:10, reset zero.
// R5 - Read-only power state field in bits 14:13, fully-on, zero.
// R6 - Read-only condition type in bits 17:15, maximum power, all ones.
// R7 - Read-only power rail in bits 20:18 reads two; upper bits reserved.
// R8 - Read-only system-allocated flag, reset zero, autoload may override.
// R9 - Downstream only: access-control header reads ID 000Dh, version 1.
// R10 - Access-control and latency headers end the chain with next pointer zero.
// R11 - Capability bits 0 to 6 read ones; bit 7 reserved.
// R12 - Bits 15:8 report applicable egress vector bits, default eight.
// R13 - Bits 16 to 22 are writable feature enables, reset zero.
// R14 - Downstream: 8-bit egress vector, reset zero, blocks matching peer requests.
// R15 - Upstream only: latency-reporting header reads ID 0018h, version 1.
// R16 - Selector 00h max, 01h sustained, other values give zero budgets.
// R17 - Power budgeting next pointer is 230h upstream, 220h downstream.
// R18 - Reserved bits read zero; absent registers do not answer as present.
// R19 - Enables act only where supported; egress vector needs its enable.
module pcie_ext_cap_power_acs_ltr_regs #(
  parameter bit UPSTREAM = 1'b0,
  parameter int EGRESS_WIDTH = 8
) (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic PREADY_OUT,
  output logic [31:0] PRDATA_OUT,
  output logic PSLVERR_OUT,
  // EEPROM autoload
  input wire logic EE_LOAD_IN,
  input wire logic [7:0] EE_BASE_POWER_IN,
  input wire logic EE_SYS_ALLOC_IN,
  // Port control
  output logic [6:0] ACS_ENABLE_OUT,
  output logic [EGRESS_WIDTH-1:0] EGRESS_BLOCK_OUT
);

  // ==========================================
  // Parameter check
  if (EGRESS_WIDTH < 1 || EGRESS_WIDTH > 8) begin : g_bad_width
    $error("EGRESS_WIDTH must be 1 to 8");
  end

  // ==========================================
  // State
  logic ready_ff;
  logic [31:0] rdata_ff;
  logic slverr_ff;
  logic [7:0] data_sel_ff;
  logic [7:0] base_power_ff;
  logic sys_alloc_ff;
  logic [6:0] acs_en_ff;
  logic [EGRESS_WIDTH-1:0] egress_ff;
  logic [6:0] acs_out_ff;
  logic [EGRESS_WIDTH-1:0] egress_out_ff;

  logic setup;
  logic wr_go;
  logic rd_setup;
  logic rd_hit;
  logic [31:0] rd_data;
  pcie_ext_cap_pkg::power_data_t pdata;
  pcie_ext_cap_pkg::cap_header_t pb_hdr;
  pcie_ext_cap_pkg::cap_header_t acs_hdr;
  pcie_ext_cap_pkg::cap_header_t ltr_hdr;
  pcie_ext_cap_pkg::acs_word_t acs_word;

  assign setup = PSEL_IN & ~PENABLE_IN;
  assign wr_go = PSEL_IN & PENABLE_IN & PWRITE_IN & ready_ff;
  assign rd_setup = setup & ~PWRITE_IN;

  // ==========================================
  // Read words
  // R17 next pointer
  assign pb_hdr = '{next_ptr: UPSTREAM ? `NEXT_UP : `NEXT_DN,
                    version: `CAP_VERSION, cap_id: `PB_CAP_ID};
  // R9 R10 access-control header
  assign acs_hdr = '{next_ptr: `NEXT_END, version: `CAP_VERSION,
                     cap_id: `ACS_CAP_ID};
  // R10 R15 latency header
  assign ltr_hdr = '{next_ptr: `NEXT_END, version: `CAP_VERSION,
                     cap_id: `LTR_CAP_ID};

  // R11 R12 R13 capability and enables
  assign acs_word = '{rsvd_hi: 9'h000, enable: acs_en_ff,
                      vec_size: 8'(EGRESS_WIDTH), rsvd_lo: 1'b0,
                      support: `ACS_CAP_BITS};

  // R16 condition selector
  always_comb begin
    pdata = '0;
    if (data_sel_ff == `SEL_MAX || data_sel_ff == `SEL_SUST) begin
      // R1 base power
      pdata.base_power = base_power_ff;
      // R3 scale field
      pdata.scale = `SCALE_RST;
      // R4 sub-state field
      pdata.sub_state = `SUBSTATE_RST;
      // R5 power state
      pdata.pm_state = `PMSTATE_RST;
      // R6 condition type
      pdata.cond_type = (data_sel_ff == `SEL_MAX) ? `TYPE_MAX : `TYPE_SUST;
      // R7 power rail
      pdata.rail = `RAIL_RST;
    end
  end

  // ==========================================
  // Address decode
  // R18 unmapped and absent answer as error
  always_comb begin
    rd_hit = 1'b1;
    rd_data = 32'h0000_0000;
    if (PADDR_IN == `PB_HDR_OFF) begin
      rd_data = pb_hdr;
    end else if (PADDR_IN == `DATA_SEL_OFF) begin
      rd_data = {24'h00_0000, data_sel_ff};
    end else if (PADDR_IN == `PB_DATA_OFF) begin
      rd_data = pdata;
    end else if (PADDR_IN == `PB_CAP_OFF) begin
      rd_data = {31'h0000_0000, sys_alloc_ff};
    end else if (PADDR_IN == `ACS_HDR_OFF && !UPSTREAM) begin
      rd_data = acs_hdr;
    end else if (PADDR_IN == `ACS_CTRL_OFF && !UPSTREAM) begin
      rd_data = acs_word;
    end else if (PADDR_IN == `EGRESS_OFF && !UPSTREAM) begin
      rd_data = 32'(egress_ff);
    end else if (PADDR_IN == `LTR_HDR_OFF && UPSTREAM) begin
      rd_data = ltr_hdr;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ==========================================
  // APB answer: one wait-free access phase
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ready_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      slverr_ff <= 1'b0;
    end else begin
      ready_ff <= setup;
      rdata_ff <= (setup && !PWRITE_IN) ? rd_data : 32'h0000_0000;
      slverr_ff <= setup & ~rd_hit;
    end
  end

  assign PREADY_OUT = ready_ff;
  assign PRDATA_OUT = rdata_ff;
  assign PSLVERR_OUT = slverr_ff;

  // ==========================================
  // Selector register
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      data_sel_ff <= `DATA_SEL_RST;
    end else if (wr_go && PADDR_IN == `DATA_SEL_OFF && PSTRB_IN[0]) begin
      data_sel_ff <= PWDATA_IN[7:0];
    end
  end

  // ==========================================
  // Autoloaded descriptors
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      base_power_ff <= `BASE_POWER_RST;
      sys_alloc_ff <= `SYS_ALLOC_RST;
    end else if (EE_LOAD_IN) begin
      // R2 base power autoload
      base_power_ff <= EE_BASE_POWER_IN;
      // R8 allocated flag autoload
      sys_alloc_ff <= EE_SYS_ALLOC_IN;
    end
  end

  // ==========================================
  // Access control enables and egress vector
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      acs_en_ff <= `ACS_EN_RST;
    end else if (wr_go && !UPSTREAM && PADDR_IN == `ACS_CTRL_OFF && PSTRB_IN[2]) begin
      // R13 writable enables
      acs_en_ff <= PWDATA_IN[`ACS_EN_LSB +: 7] & `ACS_CAP_BITS;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      egress_ff <= EGRESS_WIDTH'(`EGRESS_RST);
    end else if (wr_go && !UPSTREAM && PADDR_IN == `EGRESS_OFF && PSTRB_IN[0]) begin
      // R14 egress vector write
      egress_ff <= PWDATA_IN[EGRESS_WIDTH-1:0];
    end
  end

  // ==========================================
  // Port control outputs
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      acs_out_ff <= 7'h00;
      egress_out_ff <= '0;
    end else begin
      // R19 gated enables
      acs_out_ff <= UPSTREAM ? 7'h00 : (acs_en_ff & `ACS_CAP_BITS);
      egress_out_ff <= (!UPSTREAM && acs_en_ff[`EGRESS_EN_BIT]) ? egress_ff : '0;
    end
  end

  assign ACS_ENABLE_OUT = acs_out_ff;
  assign EGRESS_BLOCK_OUT = egress_out_ff;

  // ==========================================
  // Assertions
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN);

  ready_pulse_a: assert property ( // R18
    setup |=> PREADY_OUT ##1 !PREADY_OUT)
    else $error("ready not a single access-phase pulse");

  egress_gate_a: assert property ( // R19
    (EGRESS_BLOCK_OUT != '0) |-> $past(acs_en_ff[`EGRESS_EN_BIT]))
    else $error("egress applied without enable");

  egress_write_a: assert property ( // R14
    (wr_go && !UPSTREAM && PADDR_IN == `EGRESS_OFF && PSTRB_IN[0])
      |=> egress_ff == $past(PWDATA_IN[EGRESS_WIDTH-1:0]))
    else $error("egress vector write lost");

  base_load_a: assert property ( // R2
    EE_LOAD_IN |=> base_power_ff == $past(EE_BASE_POWER_IN))
    else $error("base power autoload lost");

  alloc_load_a: assert property ( // R8
    EE_LOAD_IN |=> sys_alloc_ff == $past(EE_SYS_ALLOC_IN))
    else $error("allocated flag autoload lost");

  power_read_a: assert property ( // R6
    (setup && !PWRITE_IN && PADDR_IN == `PB_DATA_OFF && data_sel_ff == `SEL_MAX)
      |=> PRDATA_OUT[7:0] == $past(base_power_ff) && PRDATA_OUT[31:8] == 24'h00_0b80)
    else $error("maximum power word wrong");

  zero_budget_a: assert property ( // R16
    (setup && !PWRITE_IN && PADDR_IN == `PB_DATA_OFF && data_sel_ff > `SEL_SUST)
      |=> PRDATA_OUT == 32'h0000_0000 && !PSLVERR_OUT)
    else $error("unsupported selection not zero");

  acs_header_a: assert property ( // R9
    (setup && !PWRITE_IN && PADDR_IN == `ACS_HDR_OFF)
      |=> (UPSTREAM ? PSLVERR_OUT : PRDATA_OUT == 32'h0001_000d))
    else $error("access-control header wrong");

  pb_next_a: assert property ( // R17
    (setup && !PWRITE_IN && PADDR_IN == `PB_HDR_OFF)
      |=> PRDATA_OUT[31:20] == (UPSTREAM ? 12'h230 : 12'h220))
    else $error("power budgeting next pointer wrong");

  ltr_header_a: assert property ( // R15
    (setup && !PWRITE_IN && PADDR_IN == `LTR_HDR_OFF)
      |=> (UPSTREAM ? PRDATA_OUT == 32'h0001_0018 : PSLVERR_OUT))
    else $error("latency header wrong");

  base_read_a: assert property ( // R1
    (rd_setup && PADDR_IN == `PB_DATA_OFF && data_sel_ff <= `SEL_SUST)
      |=> PRDATA_OUT[7:0] == $past(base_power_ff))
    else $error("base power byte wrong");

  scale_field_a: assert property ( // R3
    (rd_setup && PADDR_IN == `PB_DATA_OFF) |=> PRDATA_OUT[9:8] == 2'b00)
    else $error("scale field not zero");

  substate_field_a: assert property ( // R4
    (rd_setup && PADDR_IN == `PB_DATA_OFF) |=> PRDATA_OUT[12:10] == 3'b000)
    else $error("sub-state field not zero");

  pm_state_a: assert property ( // R5
    (rd_setup && PADDR_IN == `PB_DATA_OFF) |=> PRDATA_OUT[14:13] == 2'b00)
    else $error("power state not fully on");

  rail_field_a: assert property ( // R7
    (rd_setup && PADDR_IN == `PB_DATA_OFF && data_sel_ff <= `SEL_SUST)
      |=> PRDATA_OUT[20:18] == 3'b010 && PRDATA_OUT[31:21] == 11'h000)
    else $error("power rail or reserved bits wrong");

  sustained_type_a: assert property ( // R16
    (rd_setup && PADDR_IN == `PB_DATA_OFF && data_sel_ff == `SEL_SUST)
      |=> PRDATA_OUT[17:15] == `TYPE_SUST)
    else $error("sustained condition type wrong");

  alloc_read_a: assert property ( // R8
    (rd_setup && PADDR_IN == `PB_CAP_OFF)
      |=> PRDATA_OUT[0] == $past(sys_alloc_ff) && PRDATA_OUT[31:1] == 31'h0000_0000)
    else $error("allocated flag word wrong");

  chain_end_a: assert property ( // R10
    (rd_setup && (PADDR_IN == `ACS_HDR_OFF || PADDR_IN == `LTR_HDR_OFF))
      |=> PRDATA_OUT[31:20] == 12'h000)
    else $error("extended chain not ended");

  support_bits_a: assert property ( // R11
    (rd_setup && PADDR_IN == `ACS_CTRL_OFF && !UPSTREAM)
      |=> PRDATA_OUT[7:0] == 8'h7f)
    else $error("support bits wrong");

  vector_size_a: assert property ( // R12
    (rd_setup && PADDR_IN == `ACS_CTRL_OFF && !UPSTREAM)
      |=> PRDATA_OUT[15:8] == 8'(EGRESS_WIDTH))
    else $error("vector size wrong");

  enable_read_a: assert property ( // R13
    (rd_setup && PADDR_IN == `ACS_CTRL_OFF && !UPSTREAM)
      |=> PRDATA_OUT[22:16] == $past(acs_en_ff) && PRDATA_OUT[31:23] == 9'h000)
    else $error("enable field read wrong");

  enable_write_a: assert property ( // R13
    (wr_go && !UPSTREAM && PADDR_IN == `ACS_CTRL_OFF && PSTRB_IN[2])
      |=> acs_en_ff == ($past(PWDATA_IN[22:16]) & `ACS_CAP_BITS))
    else $error("enable write lost");

  enable_hold_a: assert property ( // R18
    (!(wr_go && !UPSTREAM && PADDR_IN == `ACS_CTRL_OFF && PSTRB_IN[2]))
      |=> $stable(acs_en_ff))
    else $error("enables changed without write");

  egress_hold_a: assert property ( // R18
    (!(wr_go && !UPSTREAM && PADDR_IN == `EGRESS_OFF && PSTRB_IN[0]))
      |=> $stable(egress_ff))
    else $error("egress vector changed without write");

  select_write_a: assert property ( // R16
    (wr_go && PADDR_IN == `DATA_SEL_OFF && PSTRB_IN[0])
      |=> data_sel_ff == $past(PWDATA_IN[7:0]))
    else $error("selector write lost");

  error_ready_a: assert property ( // R18
    PSLVERR_OUT |-> PREADY_OUT)
    else $error("error outside access phase");

  idle_rdata_a: assert property ( // R18
    !PREADY_OUT |-> PRDATA_OUT == 32'h0000_0000)
    else $error("read data outside access phase");

  absent_error_a: assert property ( // R18
    (setup && UPSTREAM && (PADDR_IN == `ACS_CTRL_OFF || PADDR_IN == `EGRESS_OFF))
      |=> PSLVERR_OUT)
    else $error("absent register answered");

  upstream_quiet_a: assert property ( // R19
    UPSTREAM |-> ACS_ENABLE_OUT == 7'h00 && EGRESS_BLOCK_OUT == '0)
    else $error("upstream port control active");

  enable_out_a: assert property ( // R19
    1'b1 |=> ACS_ENABLE_OUT == (UPSTREAM ? 7'h00 : ($past(acs_en_ff) & `ACS_CAP_BITS)))
    else $error("enable outputs wrong");

  egress_out_a: assert property ( // R14
    1'b1 |=> EGRESS_BLOCK_OUT == ((!UPSTREAM && $past(acs_en_ff[`EGRESS_EN_BIT]))
      ? $past(egress_ff) : '0))
    else $error("egress outputs wrong");

  write_rdata_a: assert property ( // R18
    (setup && PWRITE_IN) |=> PRDATA_OUT == 32'h0000_0000)
    else $error("write returned read data");

endmodule // pcie_ext_cap_power_acs_ltr_regs

// file: pcie_ext_cap_params.svh
`ifndef PCIE_EXT_CAP_PARAMS_SVH
`define PCIE_EXT_CAP_PARAMS_SVH

// ==========================================
// Register offsets (byte addresses)
`define PB_HDR_OFF 12'h20c
`define DATA_SEL_OFF 12'h210
`define PB_DATA_OFF 12'h214
`define PB_CAP_OFF 12'h218
`define ACS_HDR_OFF 12'h220
`define ACS_CTRL_OFF 12'h224
`define EGRESS_OFF 12'h228
`define LTR_HDR_OFF 12'h230

// ==========================================
// Capability header contents
`define PB_CAP_ID 16'h0004
`define ACS_CAP_ID 16'h000d
`define LTR_CAP_ID 16'h0018
`define CAP_VERSION 4'h1
`define NEXT_UP 12'h230
`define NEXT_DN 12'h220
`define NEXT_END 12'h000

// ==========================================
// Power budgeting reset values and selectors
`define BASE_POWER_RST 8'h04
`define SCALE_RST 2'h0
`define SUBSTATE_RST 3'h0
`define PMSTATE_RST 2'h0
`define TYPE_MAX 3'h7
`define TYPE_SUST 3'h3
`define RAIL_RST 3'h2
`define SYS_ALLOC_RST 1'h0
`define SEL_MAX 8'h00
`define SEL_SUST 8'h01
`define DATA_SEL_RST 8'h00

// ==========================================
// Access control fields
`define ACS_CAP_BITS 7'h7f
`define ACS_EN_LSB 16
`define ACS_EN_RST 7'h00
`define EGRESS_EN_BIT 5
`define EGRESS_RST 8'h00

`endif

// file: pcie_ext_cap_pkg.sv
package pcie_ext_cap_pkg;

  // ==========================================
  // Power budgeting data word
  typedef struct packed {
    logic [10:0] rsvd;
    logic [2:0] rail;
    logic [2:0] cond_type;
    logic [1:0] pm_state;
    logic [2:0] sub_state;
    logic [1:0] scale;
    logic [7:0] base_power;
  } power_data_t;

  // ==========================================
  // Extended capability header word
  typedef struct packed {
    logic [11:0] next_ptr;
    logic [3:0] version;
    logic [15:0] cap_id;
  } cap_header_t;

  // ==========================================
  // Access control capability and control word
  typedef struct packed {
    logic [8:0] rsvd_hi;
    logic [6:0] enable;
    logic [7:0] vec_size;
    logic rsvd_lo;
    logic [6:0] support;
  } acs_word_t;

endpackage

// file: tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  $display("mismatch %s exp %h got %h", nm, e, g); n_errors++; end end
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sel_up = 1'b0;
  logic ee_load = 1'b0, ee_sa = 1'b0;
  logic [7:0] ee_bp = 8'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [3:0] pstrb = 4'h0;
  logic rdy_dn, rdy_up, err_dn, err_up, rerr;
  logic [31:0] prd_dn, prd_up;
  logic [6:0] en_dn, en_up;
  logic [7:0] egr_dn, egr_up;
  int n_errors = 0, tests_run = 0, cyc = 0;
  logic [31:0] seed = 32'h5772;
  logic [7:0] m_sel [2];
  logic [7:0] m_egr, m_bp;
  logic [6:0] m_en;
  logic m_sa;
  logic [11:0] addrs [10] = '{12'h20c, 12'h210, 12'h214, 12'h218, 12'h220, 12'h224,
    12'h228, 12'h230, 12'h200, 12'h22c};

  pcie_ext_cap_power_acs_ltr_regs #(.UPSTREAM(1'b0), .EGRESS_WIDTH(8)) dut_u (
    .MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel & ~sel_up), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
    .PREADY_OUT(rdy_dn), .PRDATA_OUT(prd_dn), .PSLVERR_OUT(err_dn), .EE_LOAD_IN(ee_load),
    .EE_BASE_POWER_IN(ee_bp), .EE_SYS_ALLOC_IN(ee_sa), .ACS_ENABLE_OUT(en_dn),
    .EGRESS_BLOCK_OUT(egr_dn));
  pcie_ext_cap_power_acs_ltr_regs #(.UPSTREAM(1'b1), .EGRESS_WIDTH(8)) up_u (
    .MCLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel & sel_up), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
    .PREADY_OUT(rdy_up), .PRDATA_OUT(prd_up), .PSLVERR_OUT(err_up), .EE_LOAD_IN(ee_load),
    .EE_BASE_POWER_IN(ee_bp), .EE_SYS_ALLOC_IN(ee_sa), .ACS_ENABLE_OUT(en_up),
    .EGRESS_BLOCK_OUT(egr_up));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Bit 32 of the result is the expected error flag
  function automatic logic [32:0] expv(bit up, logic [11:0] a);
    logic [7:0] s;
    s = m_sel[up];
    case (a)
      12'h20c: return {1'b0, up ? 12'h230 : 12'h220, 4'h1, 16'h0004};
      12'h210: return {25'h0, s};
      12'h214: return (s > 8'h01) ? 33'h0 :
        {12'h0, 3'h2, (s == 8'h00) ? 3'h7 : 3'h3, 7'h0, m_bp};
      12'h218: return {32'h0, m_sa};
      12'h220: return up ? 33'h100000000 : 33'h00001000d;
      12'h224: return up ? 33'h100000000 : {10'h0, m_en, 8'h08, 8'h7f};
      12'h228: return up ? 33'h100000000 : {25'h0, m_egr};
      12'h230: return up ? 33'h000010018 : 33'h100000000;
      default: return 33'h100000000;
    endcase
  endfunction

  task automatic mreset();
    m_sel = '{8'h00, 8'h00};
    m_en = 7'h00;
    m_egr = 8'h00;
    m_bp = 8'h04;
    m_sa = 1'b0;
  endtask

  task automatic apb(bit up, bit wr, logic [11:0] a, logic [31:0] d, logic [3:0] st);
    sel_up <= up;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while ((up ? rdy_up : rdy_dn) !== 1'b1);
    rdat = up ? prd_up : prd_dn;
    rerr = up ? err_up : err_dn;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(bit up, logic [11:0] a);
    logic [32:0] e;
    e = expv(up, a);
    apb(up, 1'b0, a, 32'h0, 4'h0);
    `CHK("slverr", e[32], rerr)
    `CHK("prdata", e[31:0], rdat)
  endtask

  task automatic wr(bit up, logic [11:0] a, logic [31:0] d, logic [3:0] st);
    logic [32:0] e;
    e = expv(up, a);
    apb(up, 1'b1, a, d, st);
    `CHK("write slverr", e[32], rerr)
    if (!up && a == 12'h224 && st[2]) m_en = d[22:16];
    if (!up && a == 12'h228 && st[0]) m_egr = d[7:0];
    if (a == 12'h210 && st[0]) m_sel[up] = d[7:0];
    repeat (2) @(posedge clk);
    `CHK("acs enable", m_en, en_dn)
    `CHK("egress block", m_en[5] ? m_egr : 8'h00, egr_dn)
    `CHK("up outputs", 15'h0, {en_up, egr_up})
  endtask

  task automatic sweep();
    for (int u = 0; u < 2; u++) begin
      for (int i = 0; i < 10; i++) rd(u[0], addrs[i]);
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] r;
    mreset();
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    sweep();
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      wr(r[4], addrs[r[31:16] % 10], rnd(), r[3:0]);
      rd(r[4], addrs[r[31:16] % 10]);
    end
    wr(1'b0, 12'h224, 32'h007f_0000, 4'h4);
    for (int k = 0; k < 2; k++) begin
      r = rnd();
      wr(1'b0, 12'h228, r, 4'h1);
      rd(1'b0, 12'h228);
    end
    wr(1'b1, 12'h224, 32'h007f_0000, 4'hf);
    rd(1'b0, 12'h224);
    wr(1'b0, 12'h224, 32'h0, 4'h4);
    for (int k = 0; k < 3; k++) begin
      r = rnd();
      wr(1'b0, 12'h210, 32'h0, 4'h1);
      wr(1'b1, 12'h210, 32'h0, 4'h1);
      ee_bp <= r[7:0];
      ee_sa <= r[8];
      ee_load <= 1'b1;
      @(posedge clk);
      ee_load <= 1'b0;
      m_bp = r[7:0];
      m_sa = r[8];
      @(posedge clk);
      for (int u = 0; u < 2; u++) begin
        rd(u[0], 12'h214);
        rd(u[0], 12'h218);
      end
    end
    for (int s = 0; s < 4; s++) begin
      for (int u = 0; u < 2; u++) begin
        wr(u[0], 12'h210, (s == 3) ? 32'hff : s, 4'h1);
        rd(u[0], 12'h214);
      end
    end
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    mreset();
    @(posedge clk);
    `CHK("outputs after reset", 15'h0, {en_dn, egr_dn})
    sweep();
    conclude();
  end

  // ==========================================
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      conclude();
    end
  end
endmodule // tb
